// ---- rtl/periodic_timer.sv ----
// periodic down timer with 100 us tick, free up counter, and irq status/mask
// assumes one clock ref_clk and a single-cycle strobe register master
// Contract
// RULE1: a 16-bit programmable down timer produces recurring events.
// RULE2: the timer steps down once per 100 us tick.
// RULE3: setting enable copies preload into the current count.
// RULE4: preload becomes FFFFh at reset and when enable falls.
// RULE5: current count resets to FFFFh.
// RULE6: at 0000h the timer wraps to FFFFh, sets flag, keeps counting.
// RULE7: irq asserts only when the wrap enable is set; flag always sets.
// RULE8: wrap flag is sticky and cleared by writing one.
// RULE9: a preload write immediately replaces the current count.
// RULE10: enable clear halts the timer; enable set runs it.
// RULE11: config holds enable at bit 29, preload at 15:0, rest reserved.
// RULE12: a 32-bit up counter runs independently and is readable.
// RULE13: free counter clears in reset and adds one every cycle after.
// RULE14: free counter rolls over from all ones to zero.
// RULE15: free counter never raises an interrupt or status.
// RULE16: free counter is cleared within 160 ns of reset.
// RULE17: a prescaler makes the tick, restarting while disabled.
// RULE18: count reads are live, reserved bits zero, no side effect.
module periodic_timer (
    input wire logic ref_clk,
    input wire logic srst,
    input wire ptimer_pkg::reg_req_type regReq,
    output logic [31:0] regRdata,
    output logic irqOut
);
    logic enable_r;
    logic [15:0] preload_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [11:0] prescale_r;
    logic wrapFlag_r;
    logic wrapMask_r;
    logic [31:0] free_r;
    logic [31:0] rdata_r;
    logic irq_r;

    // address decode, shared by both strobes
    function automatic logic hit(input logic [ptimer_pkg::ADDR_W-1:0] a,
                                 input logic [ptimer_pkg::ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    wire cfgWr = regReq.wr && hit(regReq.addr, ptimer_pkg::OFS_CONFIG);
    wire staWr = regReq.wr && hit(regReq.addr, ptimer_pkg::OFS_IRQ_STATUS);
    wire mskWr = regReq.wr && hit(regReq.addr, ptimer_pkg::OFS_IRQ_MASK);
    wire newEnable = regReq.wdata[ptimer_pkg::ENABLE_BIT];
    wire [15:0] newPreload = regReq.wdata[ptimer_pkg::PRELOAD_MSB:0];
    // enable falling by software write
    wire enableFall = cfgWr && enable_r && !newEnable;
    wire enableRise = cfgWr && !enable_r && newEnable;
    // RULE17 tick prescaler
    wire tick = enable_r && (prescale_r == 12'(ptimer_pkg::TICK_CYCLES - 1));
    // RULE6 wrap detect
    wire wrapEvt = tick && (count_r == ptimer_pkg::COUNT_ZERO);

    // next count: writes win over counting so a load is never lost
    always_comb begin
        count_nxt = count_r;
        // RULE9 preload write reloads
        if (cfgWr) begin
            count_nxt = newPreload;
        // RULE2 step per tick
        end else if (tick) begin
            count_nxt = count_r - 16'h0001;
        end
    end

    // RULE17 prescaler restarts while halted so first tick is a full period
    always_ff @(posedge ref_clk) begin
        if (srst || !enable_r || tick || enableRise) begin
            prescale_r <= 12'h000;
        end else begin
            prescale_r <= prescale_r + 12'h001;
        end
    end

    // RULE11 config register: enable and preload
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enable_r <= 1'b0;
        end else if (cfgWr) begin
            enable_r <= newEnable;
        end
    end

    // RULE4 preload forced on reset and on enable fall
    always_ff @(posedge ref_clk) begin
        if (srst || enableFall) begin
            preload_r <= ptimer_pkg::PRELOAD_RESET;
        end else if (cfgWr) begin
            preload_r <= newPreload;
        end
    end

    // RULE1 16-bit down counter register
    // RULE5 count reset value; RULE3 load on enable; RULE10 halts when clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_r <= ptimer_pkg::COUNT_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

    // RULE8 sticky flag, set wins over a write-one clear
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrapFlag_r <= 1'b0;
        end else if (wrapEvt) begin
            wrapFlag_r <= 1'b1;
        end else if (staWr && regReq.wdata[ptimer_pkg::WRAP_FLAG_BIT]) begin
            wrapFlag_r <= 1'b0;
        end
    end

    // RULE7 wrap irq enable bit, reset to masked
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrapMask_r <= 1'b0;
        end else if (mskWr) begin
            wrapMask_r <= regReq.wdata[ptimer_pkg::WRAP_FLAG_BIT];
        end
    end

    // RULE7 gated level irq
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (wrapFlag_r || wrapEvt) && wrapMask_r;
        end
    end

    // RULE12 independent up counter
    // RULE13 free counter, cleared in reset; RULE14 natural rollover
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            free_r <= ptimer_pkg::FREE_RESET;
        end else begin
            free_r <= free_r + 32'h0000_0001;
        end
    end

    // RULE18 live read mux, reserved bits zero, unmapped reads zero
    wire selCfg = hit(regReq.addr, ptimer_pkg::OFS_CONFIG);
    wire selCnt = hit(regReq.addr, ptimer_pkg::OFS_COUNT);
    wire selSta = hit(regReq.addr, ptimer_pkg::OFS_IRQ_STATUS);
    wire selMsk = hit(regReq.addr, ptimer_pkg::OFS_IRQ_MASK);
    wire selFree = hit(regReq.addr, ptimer_pkg::OFS_FREE);
    wire rdMapped = selCfg || selCnt || selSta || selMsk || selFree;
    wire [31:0] cfgRead = {2'b00, enable_r, 13'h0000, preload_r};
    wire [31:0] rdSel =
        selCfg ? cfgRead :
        selCnt ? {16'h0000, count_r} :
        selSta ? {31'h0000_0000, wrapFlag_r} :
        selMsk ? {31'h0000_0000, wrapMask_r} :
        selFree ? free_r : 32'h0000_0000;

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst || !regReq.rd) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdSel;
        end
    end

    assign regRdata = rdata_r;
    assign irqOut = irq_r;

    // assertions: free counter group
    // the full 32-bit rollover is too far away for a test, so the low byte carry stands in

    // RULE13 free counter steps every cycle
    AST_FREE_INC: assert property (@(posedge ref_clk) disable iff (srst) // RULE13
        !$past(srst) |-> free_r == $past(free_r) + 32'h0000_0001)
        else $error("free counter did not increment");

    // RULE16 cleared one edge into reset
    AST_FREE_CLEAR: assert property (@(posedge ref_clk) // RULE16
        srst |=> free_r == 32'h0000_0000)
        else $error("free counter not cleared by reset");

    // RULE14 full rollover
    AST_FREE_ROLL: assert property (@(posedge ref_clk) disable iff (srst) // RULE14
        free_r == 32'hFFFF_FFFF ##1 !srst |-> free_r == 32'h0000_0000)
        else $error("free counter did not roll over");

    // RULE14 low byte carry
    AST_FREE_CARRY: assert property (@(posedge ref_clk) disable iff (srst) // RULE14
        free_r[7:0] == 8'hFF |=> free_r[7:0] == 8'h00)
        else $error("free counter low byte did not carry");

    // RULE12 free counter read is live
    AST_READ_FREE: assert property (@(posedge ref_clk) disable iff (srst) // RULE12
        regReq.rd && selFree |=> regRdata == $past(free_r))
        else $error("free counter read not live");

    // RULE15 irq only rises from the wrap flag path
    AST_IRQ_SRC: assert property (@(posedge ref_clk) disable iff (srst) // RULE15
        $rose(irqOut) |-> $past(wrapFlag_r || wrapEvt))
        else $error("irq rose without a timer wrap");

    // assertions: timer count and prescaler group

    // RULE5 count and preload reset values
    AST_COUNT_RESET: assert property (@(posedge ref_clk) // RULE5
        srst |=> count_r == 16'hFFFF && preload_r == 16'hFFFF)
        else $error("count or preload reset value wrong");

    // RULE6 wrap reloads and flags
    AST_WRAP: assert property (@(posedge ref_clk) disable iff (srst) // RULE6
        wrapEvt && !cfgWr |=> count_r == 16'hFFFF && wrapFlag_r)
        else $error("wrap did not reload and flag");

    // RULE9 preload write replaces count
    AST_PRELOAD_WR: assert property (@(posedge ref_clk) disable iff (srst) // RULE9
        cfgWr |=> count_r == $past(newPreload))
        else $error("preload write did not replace count");

    // RULE3 enable rise loads the preload
    AST_LOAD_ON_ENABLE: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
        enableRise |=> count_r == $past(newPreload) && enable_r)
        else $error("enable did not load the preload");

    // RULE10 halted count holds
    AST_HALT: assert property (@(posedge ref_clk) disable iff (srst) // RULE10
        !enable_r && !cfgWr |=> $stable(count_r))
        else $error("halted timer changed count");

    // RULE2 one step per tick
    AST_STEP: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
        tick && !cfgWr && count_r != ptimer_pkg::COUNT_ZERO
        |=> count_r == $past(count_r) - 16'h0001)
        else $error("tick did not step the count");

    // RULE2 no step between ticks
    AST_NO_STEP: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
        !tick && !cfgWr |=> $stable(count_r))
        else $error("count moved without a tick");

    // RULE2 ticks are spread apart
    AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
        tick |=> !tick [*8])
        else $error("ticks too close");

    // RULE17 prescaler stays in range
    AST_PRESCALE_RANGE: assert property (@(posedge ref_clk) disable iff (srst) // RULE17
        prescale_r <= 12'(ptimer_pkg::TICK_CYCLES - 1))
        else $error("prescaler out of range");

    // RULE17 prescaler restarts while halted
    AST_PRESCALE_HOLD: assert property (@(posedge ref_clk) disable iff (srst) // RULE17
        !enable_r |=> prescale_r == 12'h000)
        else $error("prescaler ran while halted");

    // assertions: configuration group

    // RULE4 enable fall presets preload
    AST_FALL_PRESET: assert property (@(posedge ref_clk) disable iff (srst) // RULE4
        enableFall |=> preload_r == 16'hFFFF && !enable_r)
        else $error("preload not preset on enable fall");

    // RULE4 preload only moves on a write
    AST_PRELOAD_HOLD: assert property (@(posedge ref_clk) disable iff (srst) // RULE4
        !cfgWr |=> $stable(preload_r))
        else $error("preload changed without a write");

    // RULE11 enable follows the written bit
    AST_ENABLE_WR: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
        cfgWr |=> enable_r == $past(newEnable))
        else $error("enable did not take the written bit");

    // RULE10 enable only moves on a write
    AST_ENABLE_HOLD: assert property (@(posedge ref_clk) disable iff (srst) // RULE10
        !cfgWr |=> $stable(enable_r))
        else $error("enable changed without a write");

    // RULE11 reserved config bits read zero
    AST_READ_RSVD: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
        regReq.rd && selCfg |=> regRdata[31:30] == 2'b00 && regRdata[28:16] == 13'h0000)
        else $error("reserved config bits not zero");

    // RULE11 config fields read back
    AST_CFG_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
        regReq.rd && selCfg |=> regRdata[ptimer_pkg::ENABLE_BIT] == $past(enable_r)
        && regRdata[15:0] == $past(preload_r))
        else $error("config fields read back wrong");

    // RULE18 count read is live
    AST_READ_CNT: assert property (@(posedge ref_clk) disable iff (srst) // RULE18
        regReq.rd && selCnt |=> regRdata == {16'h0000, $past(count_r)})
        else $error("count read not live");

    // RULE18 unmapped reads return zero
    AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (srst) // RULE18
        regReq.rd && !rdMapped |=> regRdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // RULE18 read data only after a strobe
    AST_READ_IDLE: assert property (@(posedge ref_clk) disable iff (srst) // RULE18
        !regReq.rd |=> regRdata == 32'h0000_0000)
        else $error("read data without a strobe");

    // assertions: status, mask and irq group

    // RULE8 flag sticky until cleared
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
        wrapFlag_r && !(staWr && regReq.wdata[ptimer_pkg::WRAP_FLAG_BIT]) |=> wrapFlag_r)
        else $error("wrap flag lost without clear");

    // RULE8 write one clears the flag
    AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
        staWr && regReq.wdata[ptimer_pkg::WRAP_FLAG_BIT] && !wrapEvt |=> !wrapFlag_r)
        else $error("write one did not clear the flag");

    // RULE8 set wins over a same cycle clear
    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
        wrapEvt |=> wrapFlag_r)
        else $error("wrap did not set the flag");

    // RULE6 flag only rises on a wrap
    AST_FLAG_SRC: assert property (@(posedge ref_clk) disable iff (srst) // RULE6
        $rose(wrapFlag_r) |-> $past(wrapEvt))
        else $error("flag set without a wrap");

    // RULE8 status read shows the flag
    AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
        regReq.rd && selSta |=> regRdata == {31'h0000_0000, $past(wrapFlag_r)})
        else $error("status read wrong");

    // RULE7 mask follows its write
    AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        mskWr |=> wrapMask_r == $past(regReq.wdata[ptimer_pkg::WRAP_FLAG_BIT]))
        else $error("mask did not take the written bit");

    // RULE7 mask only moves on a write
    AST_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        !mskWr |=> $stable(wrapMask_r))
        else $error("mask changed without a write");

    // RULE7 irq needs the enable
    AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        irqOut |-> $past(wrapMask_r))
        else $error("irq without enable");

    // RULE7 unmasked flag raises irq
    AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        wrapFlag_r && wrapMask_r |=> irqOut)
        else $error("unmasked flag did not raise irq");

    // RULE7 masked flag keeps irq low
    AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
        !wrapMask_r |=> !irqOut)
        else $error("irq high while masked");

    // RULE8 reset clears status, mask, enable and outputs
    AST_STATE_RESET: assert property (@(posedge ref_clk) // RULE8
        srst |=> !wrapFlag_r && !wrapMask_r && !enable_r && !irqOut
        && regRdata == 32'h0000_0000)
        else $error("reset did not clear status state");

    // main scenarios
    COV_WRAP: cover property (@(posedge ref_clk) disable iff (srst) wrapEvt);
    COV_IRQ: cover property (@(posedge ref_clk) disable iff (srst) $rose(irqOut));
    COV_CLEAR_SET: cover property (@(posedge ref_clk) disable iff (srst)
        wrapEvt && staWr);
    COV_FALL: cover property (@(posedge ref_clk) disable iff (srst) enableFall);
    COV_FREE_CARRY: cover property (@(posedge ref_clk) disable iff (srst)
        free_r[7:0] == 8'hFF);
endmodule // periodic_timer

// ---- pkg/ptimer_pkg.sv ----
// package for the periodic timer and free counter block
// assumes a single 20 MHz reference clock and the plain register port
package ptimer_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h8C;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h90;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h94;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h98;
    localparam logic [ADDR_W-1:0] OFS_FREE = 8'h9C;
    localparam int ENABLE_BIT = 29;
    localparam int PRELOAD_MSB = 15;
    localparam logic [15:0] PRELOAD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [31:0] FREE_RESET = 32'h0000_0000;
    localparam int WRAP_FLAG_BIT = 0;
    // timing: tick period and reference clock rate
    localparam int TICK_PERIOD_NS = 100000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FREE_CLEAR_NS = 160;
    localparam int FREE_CLEAR_CYCLES = FREE_CLEAR_NS / CLK_PERIOD_NS;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } reg_req_type;
endpackage

// ---- testbench/testbench.sv ----
// self-checking bench for the periodic timer and free counter block
// assumes the register port of ptimer_pkg and a 20 MHz ref_clk
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic srst;
    ptimer_pkg::reg_req_type regReq;
    logic [31:0] regRdata;
    logic irqOut;
    int fail_count;
    int total_checks;
    logic [31:0] rv;
    logic [31:0] fa;

    periodic_timer dut (
        .ref_clk(ref_clk),
        .srst(srst),
        .regReq(regReq),
        .regRdata(regRdata),
        .irqOut(irqOut)
    );

    // 50 ns period clock
    always #25 ref_clk = ~ref_clk;

    // one strobe cycle, released only after the taking edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regReq <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge ref_clk);
        regReq <= '0;
        #1;
        rv = regRdata;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence: reset values, then timer runs, wrap, irq and halts
    initial begin
        ref_clk = 1'b0;
        srst = 1'b1;
        regReq = '0;
        fail_count = 0;
        total_checks = 0;
        idle(3);
        srst <= 1'b0;
        xfer(1'b0, ptimer_pkg::OFS_FREE, 32'h0); check("free after reset", 32'h1, rv);
        xfer(1'b0, ptimer_pkg::OFS_CONFIG, 32'h0); check("config reset", 32'h0000FFFF, rv);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count reset", 32'h0000FFFF, rv);
        xfer(1'b0, ptimer_pkg::OFS_IRQ_STATUS, 32'h0); check("status reset", 32'h0, rv);
        xfer(1'b0, ptimer_pkg::OFS_IRQ_MASK, 32'h0); check("mask reset", 32'h0, rv);
        // enable with preload 3; ticks every 2000 cycles from here
        xfer(1'b1, ptimer_pkg::OFS_CONFIG, 32'h20000003);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count loaded", 32'h3, rv);
        idle(1000);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count before tick", 32'h3, rv);
        idle(1200);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count one tick", 32'h2, rv);
        xfer(1'b0, ptimer_pkg::OFS_IRQ_STATUS, 32'h0); check("status early", 32'h0, rv);
        idle(5900);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count wrapped", 32'h0000FFFF, rv);
        xfer(1'b0, ptimer_pkg::OFS_IRQ_STATUS, 32'h0); check("flag set", 32'h1, rv);
        check("irq masked", 32'h0, {31'h0, irqOut});
        xfer(1'b1, ptimer_pkg::OFS_IRQ_MASK, 32'h1);
        idle(2);
        #1;
        check("irq unmasked", 32'h1, {31'h0, irqOut});
        xfer(1'b1, ptimer_pkg::OFS_IRQ_STATUS, 32'h0);
        xfer(1'b0, ptimer_pkg::OFS_IRQ_STATUS, 32'h0); check("flag sticky", 32'h1, rv);
        xfer(1'b1, ptimer_pkg::OFS_IRQ_STATUS, 32'h1);
        idle(2);
        #1;
        check("irq cleared", 32'h0, {31'h0, irqOut});
        xfer(1'b0, ptimer_pkg::OFS_IRQ_STATUS, 32'h0); check("flag cleared", 32'h0, rv);
        // reload while running keeps counting from the new value
        xfer(1'b1, ptimer_pkg::OFS_CONFIG, 32'h20000007);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("reload running", 32'h7, rv);
        // two back to back reads of the free counter are two edges apart
        xfer(1'b0, ptimer_pkg::OFS_FREE, 32'h0);
        fa = rv;
        xfer(1'b0, ptimer_pkg::OFS_FREE, 32'h0); check("free step", 32'h2, rv - fa);
        // enable fall presets preload, count takes the written value
        xfer(1'b1, ptimer_pkg::OFS_CONFIG, 32'h00001234);
        xfer(1'b0, ptimer_pkg::OFS_CONFIG, 32'h0); check("preload preset", 32'h0000FFFF, rv);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count written", 32'h1234, rv);
        idle(2500);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count halted", 32'h1234, rv);
        // reserved bits set and enable clear in one write
        xfer(1'b1, ptimer_pkg::OFS_CONFIG, 32'hDFFF0042);
        xfer(1'b0, ptimer_pkg::OFS_CONFIG, 32'h0); check("config reserved", 32'h42, rv);
        xfer(1'b0, ptimer_pkg::OFS_COUNT, 32'h0); check("count idle load", 32'h42, rv);
        xfer(1'b0, 8'h00, 32'h0); check("unmapped read", 32'h0, rv);
        check("no irq at end", 32'h0, {31'h0, irqOut});
        // mid-run reset must clear the free counter and config again
        @(posedge ref_clk);
        srst <= 1'b1;
        idle(3);
        srst <= 1'b0;
        xfer(1'b0, ptimer_pkg::OFS_FREE, 32'h0); check("free mid reset", 32'h1, rv);
        xfer(1'b0, ptimer_pkg::OFS_CONFIG, 32'h0); check("config mid reset", 32'h0000FFFF, rv);
        check("irq mid reset", 32'h0, {31'h0, irqOut});
        summarize();
    end
endmodule // testbench
